// file: common/resampler_defines.svh
// Constants for the fractional-rate polyphase resampler.
// Assumes inclusion by bare name from the design and bench sources.
`ifndef RESAMPLER_DEFINES_SVH
`define RESAMPLER_DEFINES_SVH
`define RS_DATA_W      16
`define RS_COEF_W      16
`define RS_ACC_W       38
`define RS_NTAPS       64
`define RS_TAP_AW      6
`define RS_FACTOR_W    7
`define RS_MAX_FACTOR  7'h40
`define RS_FIFO_DEPTH  16
`endif

// file: common/resampler_pkg.sv
// Types used by the resampler design; the bench does not import them.
// Assumes resampler_defines.svh is on the include path.
`default_nettype none
package resampler_pkg;
    typedef enum logic [1:0] {
        S_FILL,
        S_MAC,
        S_EMIT,
        S_STEP
    } engine_state_e;
endpackage : resampler_pkg
`default_nettype wire

// file: design/fractional_rate_polyphase_resampler.sv
// Fixed fractional-rate P/Q polyphase resampler on one serial MAC engine,
// with its input FIFO. Assumes stable factors while rst_n_i is low.
`include "resampler_defines.svh"
`default_nettype none

module sample_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          push;
    logic          pop;

    assign in_ready_o  = (count != D[AW:0]);
    assign out_valid_o = (count != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : sample_fifo

module fractional_rate_polyphase_resampler
    import resampler_pkg::*;
(
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    input  wire logic [`RS_FACTOR_W-1:0]   up_factor_i,
    input  wire logic [`RS_FACTOR_W-1:0]   down_factor_i,
    input  wire logic                      coef_we_i,
    input  wire logic [`RS_TAP_AW-1:0]     coef_addr_i,
    input  wire logic [`RS_COEF_W-1:0]     coef_data_i,
    input  wire logic [`RS_DATA_W-1:0]     in_data_i,
    input  wire logic                      in_valid_i,
    output logic                           in_ready_o,
    output logic [`RS_ACC_W-1:0]           out_data_o,
    output logic                           out_valid_o,
    input  wire logic                      out_ready_i
);
    localparam logic [7:0] NTAPS = 8'(`RS_NTAPS);

    logic signed [`RS_COEF_W-1:0] coef [`RS_NTAPS];
    logic signed [`RS_DATA_W-1:0] hist [`RS_NTAPS];
    logic [`RS_FACTOR_W-1:0]      up_factor;
    logic [`RS_FACTOR_W-1:0]      down_factor;
    engine_state_e                state;
    logic [7:0]                   phase;
    logic [7:0]                   tap;
    logic [`RS_TAP_AW-1:0]        k;
    logic [`RS_FACTOR_W-1:0]      pending;
    logic signed [`RS_ACC_W-1:0]  acc;
    logic signed [`RS_ACC_W-1:0]  prod;
    logic [`RS_DATA_W-1:0]        fifo_data;
    logic                         fifo_valid;
    logic                         fifo_pop;
    logic [7:0]                   next_tap;

    function automatic logic [`RS_FACTOR_W-1:0] legal_factor(
        input logic [`RS_FACTOR_W-1:0] f
    );
        // Out-of-range straps fall back to unity rather than hang the engine
        if (f == '0 || f > `RS_MAX_FACTOR)
        begin
            return 7'h01;
        end
        return f;
    endfunction : legal_factor

    // Input buffering absorbs bursts while the engine runs its tap loop
    sample_fifo #(
        .W (`RS_DATA_W),
        .D (`RS_FIFO_DEPTH)
    ) u_in_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (in_data_i),
        .in_valid_i  (in_valid_i),
        .in_ready_o  (in_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    assign fifo_pop    = (state == S_FILL) && (pending != '0);
    assign out_valid_o = (state == S_EMIT);
    assign prod        = `RS_ACC_W'(coef[tap[`RS_TAP_AW-1:0]] * hist[k]);
    assign next_tap    = tap + 8'(up_factor);

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            up_factor   <= legal_factor(up_factor_i);
            down_factor <= legal_factor(down_factor_i);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (coef_we_i)
        begin
            coef[coef_addr_i] <= coef_data_i;
        end
    end

    // History shifts by one per consumed input; arms are P-strided coefficient taps
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < `RS_NTAPS; i++)
            begin
                hist[i] <= '0;
            end
        end
        else if (fifo_pop && fifo_valid)
        begin
            hist[0] <= fifo_data;
            for (int i = 1; i < `RS_NTAPS; i++)
            begin
                hist[i] <= hist[i-1];
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state      <= S_FILL;
            phase      <= '0;
            pending    <= 7'h01;
            tap        <= '0;
            k          <= '0;
            acc        <= '0;
            out_data_o <= '0;
        end
        else
        begin
            case (state)
                S_FILL:
                begin
                    if (pending == '0)
                    begin
                        state <= S_MAC;
                        tap   <= phase;
                        k     <= '0;
                        acc   <= '0;
                    end
                    else if (fifo_valid)
                    begin
                        pending <= pending - 1'b1;
                    end
                end
                S_MAC:
                begin
                    // Only the live arm's taps: zero-stuffed products skipped
                    acc <= acc + prod;
                    tap <= next_tap;
                    k   <= k + 1'b1;
                    if (next_tap >= NTAPS)
                    begin
                        out_data_o <= acc + prod;
                        state      <= S_EMIT;
                    end
                end
                S_EMIT:
                begin
                    if (out_ready_i)
                    begin
                        phase <= phase + 8'(down_factor);
                        state <= S_STEP;
                    end
                end
                S_STEP:
                begin
                    // Each wrap past the last arm costs one new input
                    if (phase >= 8'(up_factor))
                    begin
                        phase   <= phase - 8'(up_factor);
                        pending <= pending + 1'b1;
                    end
                    else
                    begin
                        state <= S_FILL;
                    end
                end
                default:
                begin
                    state <= S_FILL;
                end
            endcase
        end
    end

    a_factor_range: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        up_factor != '0 && up_factor <= `RS_MAX_FACTOR
        && down_factor != '0 && down_factor <= `RS_MAX_FACTOR)
        else $error("factor out of range");

    a_arm_in_range: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == S_FILL |-> phase < 8'(up_factor))
        else $error("arm index not below P");

    a_mac_starts_arm: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == S_FILL && pending == '0 |=> state == S_MAC && tap == $past(phase)
        && k == '0 && acc == '0)
        else $error("MAC did not start on the selected arm");

    a_tap_stride: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == S_MAC && $past(state) == S_MAC
        |-> tap == $past(tap) + 8'(up_factor) && k == $past(k) + 1'b1)
        else $error("tap stride not P");

    a_mac_sum: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == S_MAC ##1 state == S_MAC |-> acc == $past(acc) + $past(prod))
        else $error("accumulator missed a product");

    a_arms_summed: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == S_MAC && next_tap >= NTAPS |=> state == S_EMIT
        && out_data_o == $past(acc) + $past(prod))
        else $error("output not the full arm sum");

    a_input_shift: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        fifo_pop && fifo_valid |=> hist[0] == $past(fifo_data)
        && pending == $past(pending) - 1'b1)
        else $error("input not shifted in");

    a_step_wraps: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == S_EMIT && out_ready_i |=> state == S_STEP
        ##[1:65] state == S_FILL && phase < 8'(up_factor)
        && pending <= `RS_MAX_FACTOR)
        else $error("phase step did not settle");

    a_output_held: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("output dropped before accept");
endmodule : fractional_rate_polyphase_resampler
`default_nettype wire

// file: test/stream_partner.sv
// Upstream sample source and downstream result sink for the resampler.
// Assumes one clock; the bench sets the word count and the stall level.
`default_nettype none
module stream_partner (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  n_words_i,
    input  wire logic        stall_i,
    output logic [15:0]      src_data_o,
    output logic             src_valid_o,
    input  wire logic        src_ready_i,
    input  wire logic [37:0] sink_data_i,
    input  wire logic        sink_valid_i,
    output logic             sink_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  sent;
    logic [7:0]  got_n;
    logic [37:0] got [0:63];
    assign src_valid_o = sent < n_words_i;
    // Idle data is inverted so a stale word never passes for a fresh one
    assign src_data_o = src_valid_o ? 16'(sent * 37 % 501 - 250)
                                    : ~16'(sent * 37 % 501 - 250);
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            sent  <= 8'h00;
            got_n <= 8'h00;
        end
        else
        begin
            if (src_valid_o && src_ready_i)
                sent <= sent + 8'h01;
            if (sink_valid_i && sink_ready_o && got_n < 8'h40)
            begin
                got[got_n[5:0]] <= sink_data_i;
                got_n           <= got_n + 8'h01;
            end
        end
    end
    always_ff @(posedge clock_i)
        sink_ready_o <= !stall_i;
endmodule : stream_partner
`default_nettype wire

// file: test/fractional_rate_polyphase_resampler_bench.sv
// Self-checking bench for the polyphase resampler.
// Assumes stream_partner stands in for both stream neighbours.
`include "resampler_defines.svh"
`default_nettype none
module fractional_rate_polyphase_resampler_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [6:0]  up = 7'h01;
    logic [6:0]  down = 7'h01;
    logic        coef_we = 1'b0;
    logic [5:0]  coef_addr = 6'h00;
    logic [15:0] coef_data = 16'h0000;
    logic [7:0]  n_words = 8'h00;
    logic        stall = 1'b0;
    logic [15:0] in_data;
    logic        in_valid, in_ready, out_valid, out_ready;
    logic [37:0] out_data;
    int          fails = 0;
    int          check_count = 0;
    always #20 clock = ~clock;
    fractional_rate_polyphase_resampler dut (
        .clock_i(clock), .rst_n_i(rst_n),
        .up_factor_i(up), .down_factor_i(down),
        .coef_we_i(coef_we), .coef_addr_i(coef_addr),
        .coef_data_i(coef_data), .in_data_i(in_data),
        .in_valid_i(in_valid), .in_ready_o(in_ready),
        .out_data_o(out_data), .out_valid_o(out_valid),
        .out_ready_i(out_ready));
    stream_partner u_partner (
        .clock_i(clock), .rst_n_i(rst_n), .n_words_i(n_words),
        .stall_i(stall), .src_data_o(in_data), .src_valid_o(in_valid),
        .src_ready_i(in_ready), .sink_data_i(out_data),
        .sink_valid_i(out_valid), .sink_ready_o(out_ready));
    function automatic logic signed [15:0] coef(input int i);
        return 16'(i * 3 - 90);
    endfunction : coef
    function automatic logic signed [15:0] sample(input int m);
        return 16'(m * 37 % 501 - 250);
    endfunction : sample
    task automatic finish_test();
        if (fails == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic check_word(input string what, input logic [37:0] e, g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : check_word
    task automatic check_flag(input string what, input logic e, g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask : check_flag
    // Expected results come from the direct P/Q polyphase sum, not the engine
    task automatic run_case(input int p, q, n, input bit hold);
        logic signed [37:0] e [0:63];
        int m, ph, idx, k, t, pe, qe;
        // Out-of-range straps behave as unity
        pe = (p < 1 || p > 64) ? 1 : p;
        qe = (q < 1 || q > 64) ? 1 : q;
        m = 0;
        ph = 0;
        idx = 0;
        while (idx < n)
        begin
            e[m] = '0;
            for (k = 0; ph + k * pe < 64 && idx - k >= 0; k++)
                e[m] = e[m] + coef(ph + k * pe) * sample(idx - k);
            m++;
            ph += qe;
            while (ph >= pe)
            begin
                ph -= pe;
                idx++;
            end
        end
        rst_n = 1'b0;
        up = 7'(p);
        down = 7'(q);
        stall = hold;
        n_words = 8'h00;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        coef_we = 1'b1;
        for (k = 0; k < 64; k++)
        begin
            coef_addr = 6'(k);
            coef_data = coef(k);
            @(negedge clock);
        end
        coef_we = 1'b0;
        n_words = 8'(n);
        for (t = 0; hold && in_ready !== 1'b0 && t < 200; t++)
            @(negedge clock);
        if (hold)
            check_flag("in_ready_full", 1'b0, in_ready);
        if (hold && t == 200)
            finish_test();
        stall = 1'b0;
        for (t = 0; u_partner.got_n < 8'(m) && t < 20000; t++)
            @(negedge clock);
        if (t == 20000)
        begin
            fails++;
            finish_test();
        end
        repeat (300) @(negedge clock);
        check_word("out_count", 38'(m), 38'(u_partner.got_n));
        check_flag("in_ready_empty", 1'b1, in_ready);
        for (k = 0; k < m; k++)
            check_word("out_data", e[k], u_partner.got[k]);
    endtask : run_case
    initial
    begin
        @(negedge clock);
        run_case(1, 1, 20, 1'b1);
        run_case(4, 1, 5, 1'b0);
        run_case(5, 3, 9, 1'b0);
        run_case(1, 5, 20, 1'b0);
        run_case(3, 5, 20, 1'b0);
        run_case(64, 64, 6, 1'b0);
        run_case(64, 1, 1, 1'b0);
        run_case(0, 100, 6, 1'b0);
        finish_test();
    end
endmodule : fractional_rate_polyphase_resampler_bench
`default_nettype wire
